// ==== rxs_pkg.sv ====
package rxs_pkg;
  localparam int          RXS_NUM_COUNTERS   = 8;
  localparam int          RXS_HALF_BIT       = 31;
  // counter indices, counters sit at byte offset 4 * index
  localparam int          RXS_CNT_GOOD       = 0;
  localparam int          RXS_CNT_BCAST      = 1;
  localparam int          RXS_CNT_MCAST      = 2;
  localparam int          RXS_CNT_PAUSE      = 3;
  localparam int          RXS_CNT_CRC        = 4;
  localparam int          RXS_CNT_ALIGN      = 5;
  localparam int          RXS_CNT_OVER       = 6;
  localparam int          RXS_CNT_JABBER     = 7;
  // register byte offsets
  localparam logic [7:0]  RXS_OFS_CNT_BASE   = 8'h00;
  localparam logic [7:0]  RXS_OFS_CNT_LAST   = 8'h1C;
  localparam logic [7:0]  RXS_OFS_RAW_STAT   = 8'h20;
  localparam logic [7:0]  RXS_OFS_MASKED     = 8'h24;
  localparam logic [7:0]  RXS_OFS_MASK_SET   = 8'h28;
  localparam logic [7:0]  RXS_OFS_MASK_CLR   = 8'h2C;
  localparam logic [7:0]  RXS_OFS_MAX_LEN    = 8'h30;
  localparam logic [7:0]  RXS_OFS_PORT_CTRL  = 8'h34;
  localparam logic [7:0]  RXS_OFS_WRAP_STAT  = 8'h38;
  localparam logic [7:0]  RXS_OFS_WRAP_CLR   = 8'h3C;
  localparam logic [7:0]  RXS_OFS_WRAP_EN    = 8'h40;
  // field positions and reset values
  localparam int          RXS_STATS_IRQ_PENDING_BIT  = 0;
  localparam int          RXS_PAUSE_EN_BIT   = 0;
  localparam logic [15:0] RXS_MAX_LEN_RESET  = 16'h05EE;
  localparam logic [31:0] RXS_COUNT_RESET    = 32'h0000_0000;
  // frame classification constants
  localparam logic [15:0] RXS_MIN_FRAME_LEN  = 16'h0040;
  localparam logic [15:0] RXS_PAUSE_TYPE     = 16'h8808;
  localparam logic [15:0] RXS_PAUSE_OPCODE   = 16'h0001;
  localparam logic [47:0] RXS_BCAST_ADDR     = 48'hFFFF_FFFF_FFFF;
  localparam int          RXS_MCAST_BIT      = 40;

  typedef enum logic [1:0] {
    RXS_BUS_IDLE = 2'b01,
    RXS_BUS_ACK  = 2'b10
  } rxs_bus_state_type;
endpackage

// ==== rxs_stat_counter.sv ====
`timescale 1ns/1ps
module rxs_stat_counter
  import rxs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // update requests
  input  wire logic        inc,
  input  wire logic        sub_valid,
  input  wire logic [31:0] sub_value,
  // state
  output logic      [31:0] count,
  output logic             wrapped
);
  logic [31:0] next_count;

  // increment and decrement fold into one update so neither is lost
  always_comb begin
    next_count = count + {31'h0000_0000, inc} - (sub_valid ? sub_value : 32'h0000_0000);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= RXS_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  assign wrapped = inc && (count == 32'hFFFF_FFFF);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_cnt_inc_only: assert property (inc && !sub_valid |=> count == $past(count) + 32'h0000_0001)
    else $error("counter did not step by one");
  chk_cnt_wrap_zero: assert property (inc && !sub_valid && count == 32'hFFFF_FFFF |=> count == 32'h0000_0000)
    else $error("counter did not wrap to zero");
  chk_cnt_sub_only: assert property (sub_valid && !inc |=> count == $past(count) - $past(sub_value))
    else $error("write did not subtract");
  chk_cnt_both_kept: assert property (sub_valid && inc
      |=> count == $past(count) - $past(sub_value) + 32'h0000_0001)
    else $error("increment lost beside write");
endmodule

// ==== rxs_rx_statistics.sv ====
// Contract
// - raise statistics pending irq, when enabled, while any counter is at least 8000_0000h
// - software decrements counters; pending drops once none remains at or above half scale
// - each counter is 32 bits, memory mapped, wrapping from all-ones to zero
// - good counter: matched data/control frame, 64..max length, no crc/align/code error
// - broadcast counter: error-free all-ones destination frame of 64..max length
// - multicast counter: error-free non-broadcast multicast frame of 64..max length
// - pause counter: error-free 8808h/0001h frame of valid length, only with pause enable
// - receive overruns never affect any counter
// - crc counter: matched frame 64..max length, crc error, no code or alignment error
// - crc error means even nibble count and failed frame check
// - align/code counter: matched frame 64..max length with alignment or code error
// - alignment error means odd nibble count and failed check without last nibble
// - receive error input high anytime during a frame flags a code error
// - oversize counter: matched frame above max length with no error
// - jabber counter: matched frame above max length with any error
// - mask bit gates pending onto irq; set location enables, clear location disables
// - pending is readable raw and masked
`timescale 1ns/1ps
module rxs_rx_statistics
  import rxs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // receive path frame status
  input  wire logic        rx_frame_active,
  input  wire logic        rx_error_input,
  input  wire logic        rx_frame_done,
  input  wire logic [15:0] rx_frame_length,
  input  wire logic [47:0] rx_dest_addr,
  input  wire logic        rx_addr_match,
  input  wire logic        rx_is_data_or_ctrl,
  input  wire logic [15:0] rx_type_length,
  input  wire logic [15:0] rx_opcode,
  input  wire logic        rx_odd_nibbles,
  input  wire logic        rx_fcs_fail,
  // interrupt
  output logic             stats_irq
);
  rxs_bus_state_type bus_state;
  logic [31:0] count [RXS_NUM_COUNTERS];
  logic [RXS_NUM_COUNTERS-1:0] inc_q;
  logic [RXS_NUM_COUNTERS-1:0] next_inc;
  logic [RXS_NUM_COUNTERS-1:0] sub_hit;
  logic [RXS_NUM_COUNTERS-1:0] wrap_pulse;
  logic [RXS_NUM_COUNTERS-1:0] wrap_status;
  logic [RXS_NUM_COUNTERS-1:0] wrap_enable;
  logic [RXS_NUM_COUNTERS-1:0] half_bits;
  logic [31:0] wdata_be;
  logic [31:0] next_readdata;
  logic [15:0] rx_max_frame_length;
  logic        port_pause_flow_en;
  logic        stats_irq_pending;
  logic        stat_int_mask;
  logic        code_seen;
  logic        bus_req;
  logic        bus_wr_go;
  logic        in_frame;
  logic        len_ok;
  logic        len_over;
  logic        crc_err;
  logic        align_err;
  logic        code_err;
  logic        any_err;
  logic        is_bcast;
  logic        is_mcast;
  logic        is_pause;

  // bus handshake: one wait cycle, so every access completes two edges after it is raised
  assign bus_req   = avs_read || avs_write;
  assign bus_wr_go = avs_write && (bus_state == RXS_BUS_ACK);
  assign wdata_be  = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_state       <= RXS_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (bus_state)
        RXS_BUS_IDLE: begin
          if (bus_req) begin
            bus_state       <= RXS_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        RXS_BUS_ACK: begin
          bus_state       <= RXS_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (avs_address <= RXS_OFS_CNT_LAST && avs_address[1:0] == 2'b00) begin
      next_readdata = count[avs_address[4:2]];
    end else begin
      unique case (avs_address)
        RXS_OFS_RAW_STAT:  next_readdata[RXS_STATS_IRQ_PENDING_BIT] = stats_irq_pending;
        RXS_OFS_MASKED:    next_readdata[RXS_STATS_IRQ_PENDING_BIT] = stats_irq_pending && stat_int_mask;
        RXS_OFS_MASK_SET:  next_readdata[RXS_STATS_IRQ_PENDING_BIT] = stat_int_mask;
        RXS_OFS_MASK_CLR:  next_readdata[RXS_STATS_IRQ_PENDING_BIT] = stat_int_mask;
        RXS_OFS_MAX_LEN:   next_readdata[15:0] = rx_max_frame_length;
        RXS_OFS_PORT_CTRL: next_readdata[RXS_PAUSE_EN_BIT] = port_pause_flow_en;
        RXS_OFS_WRAP_STAT: next_readdata[RXS_NUM_COUNTERS-1:0] = wrap_status;
        RXS_OFS_WRAP_EN:   next_readdata[RXS_NUM_COUNTERS-1:0] = wrap_enable;
        default:           next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // read data is captured while waitrequest is still high and stands through the ack cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_state == RXS_BUS_IDLE) begin
      avs_readdata <= next_readdata;
    end
  end

  // control registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_max_frame_length <= RXS_MAX_LEN_RESET;
      port_pause_flow_en  <= 1'b0;
      stat_int_mask       <= 1'b0;
      wrap_enable         <= '0;
    end else if (bus_wr_go) begin
      unique case (avs_address)
        RXS_OFS_MAX_LEN:   rx_max_frame_length <= wdata_be[15:0];
        RXS_OFS_PORT_CTRL: port_pause_flow_en <= wdata_be[RXS_PAUSE_EN_BIT];
        RXS_OFS_WRAP_EN:   wrap_enable <= wdata_be[RXS_NUM_COUNTERS-1:0];
        RXS_OFS_MASK_SET: begin
          if (wdata_be[RXS_STATS_IRQ_PENDING_BIT]) begin
            stat_int_mask <= 1'b1;
          end
        end
        RXS_OFS_MASK_CLR: begin
          if (wdata_be[RXS_STATS_IRQ_PENDING_BIT]) begin
            stat_int_mask <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // code error is latched across the frame; cleared as the frame ends
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      code_seen <= 1'b0;
    end else if (rx_frame_done) begin
      code_seen <= 1'b0;
    end else if (rx_frame_active && rx_error_input) begin
      code_seen <= 1'b1;
    end
  end

  // overrun status is deliberately not an input: it never alters classification
  assign in_frame  = rx_frame_done && rx_is_data_or_ctrl && rx_addr_match;
  assign len_ok    = rx_frame_length >= RXS_MIN_FRAME_LEN && rx_frame_length <= rx_max_frame_length;
  assign len_over  = rx_frame_length > rx_max_frame_length;
  assign crc_err   = rx_fcs_fail && !rx_odd_nibbles;
  assign align_err = rx_fcs_fail && rx_odd_nibbles;
  assign code_err  = code_seen || rx_error_input;
  assign any_err   = crc_err || align_err || code_err;
  assign is_bcast  = rx_dest_addr == RXS_BCAST_ADDR;
  assign is_mcast  = rx_dest_addr[RXS_MCAST_BIT] && !is_bcast;
  assign is_pause  = rx_type_length == RXS_PAUSE_TYPE && rx_opcode == RXS_PAUSE_OPCODE;

  always_comb begin
    next_inc                 = '0;
    next_inc[RXS_CNT_GOOD]   = in_frame && len_ok && !any_err;
    next_inc[RXS_CNT_BCAST]  = in_frame && len_ok && !any_err && is_bcast;
    next_inc[RXS_CNT_MCAST]  = in_frame && len_ok && !any_err && is_mcast;
    next_inc[RXS_CNT_PAUSE]  = in_frame && len_ok && !any_err && is_pause
                               && port_pause_flow_en;
    next_inc[RXS_CNT_CRC]    = in_frame && len_ok && crc_err && !code_err;
    next_inc[RXS_CNT_ALIGN]  = in_frame && len_ok && (align_err || code_err);
    next_inc[RXS_CNT_OVER]   = in_frame && len_over && !any_err;
    next_inc[RXS_CNT_JABBER] = in_frame && len_over && any_err;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      inc_q <= '0;
    end else begin
      inc_q <= next_inc;
    end
  end

  for (genvar i = 0; i < RXS_NUM_COUNTERS; i++) begin : g_cnt
    // a write to a counter is a decrement by the written value
    assign sub_hit[i]   = bus_wr_go && avs_address[7:2] == (RXS_OFS_CNT_BASE[7:2] + 6'(i));
    assign half_bits[i] = count[i][RXS_HALF_BIT];
    rxs_stat_counter u_cnt (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .inc       (inc_q[i]),
      .sub_valid (sub_hit[i]),
      .sub_value (wdata_be),
      .count     (count[i]),
      .wrapped   (wrap_pulse[i])
    );
  end

  // pending is a level: it follows the counters, so decrements or a counter wrapping to zero remove it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stats_irq_pending <= 1'b0;
    end else begin
      stats_irq_pending <= |half_bits;
    end
  end

  // sticky wrap flags; a wrap in the clearing cycle survives
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wrap_status <= '0;
    end else if (bus_wr_go && avs_address == RXS_OFS_WRAP_CLR) begin
      wrap_status <= (wrap_status & ~wdata_be[RXS_NUM_COUNTERS-1:0]) | wrap_pulse;
    end else begin
      wrap_status <= wrap_status | wrap_pulse;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stats_irq <= 1'b0;
    end else begin
      stats_irq <= (stats_irq_pending && stat_int_mask) || |(wrap_status & wrap_enable);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_err_in_frame;
    rx_frame_active && rx_error_input && !rx_frame_done;
  endsequence
  sequence s_err_frame_end;
    rx_frame_done && in_frame && len_ok && !align_err;
  endsequence

  chk_pend_raise_irq: assert property (|half_bits && stat_int_mask
      ##1 stat_int_mask |=> stats_irq)
    else $error("irq missing with half-scale counter");
  chk_pend_drops_clear: assert property (!(|half_bits) |=> !stats_irq_pending)
    else $error("pending stayed without half-scale counter");
  chk_mask_gates_irq: assert property (!stat_int_mask && !(|wrap_status) |=> !stats_irq)
    else $error("irq raised while masked");
  chk_good_frame_count: assert property (in_frame && len_ok && !any_err |=> inc_q[RXS_CNT_GOOD])
    else $error("good frame not counted");
  chk_bcast_mcast_excl: assert property (inc_q[RXS_CNT_MCAST] |-> !inc_q[RXS_CNT_BCAST])
    else $error("broadcast counted as multicast");
  chk_pause_needs_enable: assert property (!port_pause_flow_en |=> !inc_q[RXS_CNT_PAUSE])
    else $error("pause counted while disabled");
  chk_crc_even_nibbles: assert property (in_frame && len_ok && rx_fcs_fail
      && rx_odd_nibbles |=> !inc_q[RXS_CNT_CRC] && inc_q[RXS_CNT_ALIGN])
    else $error("odd nibble frame misclassed");
  chk_code_err_frame: assert property (s_err_in_frame ##1 !rx_frame_done
      ##1 s_err_frame_end |=> inc_q[RXS_CNT_ALIGN])
    else $error("code error not counted");
  chk_oversize_split: assert property (in_frame && len_over
      |=> inc_q[RXS_CNT_OVER] != inc_q[RXS_CNT_JABBER] && !inc_q[RXS_CNT_GOOD])
    else $error("oversize frame misclassed");
  chk_raw_read_pend: assert property (avs_read && bus_state == RXS_BUS_IDLE
      && avs_address == RXS_OFS_RAW_STAT |=> avs_readdata[0] == $past(stats_irq_pending))
    else $error("raw pending read wrong");

  // frame classes, seen on the strobe one edge after done
  sequence s_good_frame;
    in_frame && len_ok && !any_err;
  endsequence

  chk_bcast_count: assert property (s_good_frame ##0 is_bcast |=> inc_q[RXS_CNT_BCAST])
    else $error("broadcast not counted");
  chk_bcast_also_good: assert property (inc_q[RXS_CNT_BCAST] |-> inc_q[RXS_CNT_GOOD])
    else $error("broadcast not good");
  chk_mcast_count: assert property (s_good_frame ##0 is_mcast |=> inc_q[RXS_CNT_MCAST])
    else $error("multicast not counted");
  chk_pause_count: assert property (s_good_frame ##0 (is_pause && port_pause_flow_en)
      |=> inc_q[RXS_CNT_PAUSE])
    else $error("pause not counted");
  chk_pause_also_good: assert property (inc_q[RXS_CNT_PAUSE] |-> inc_q[RXS_CNT_GOOD])
    else $error("pause not good");
  chk_crc_count: assert property (in_frame && len_ok && crc_err && !code_err
      |=> inc_q[RXS_CNT_CRC] && !inc_q[RXS_CNT_ALIGN])
    else $error("crc frame misclassed");
  chk_crc_even_fail: assert property (inc_q[RXS_CNT_CRC]
      |-> !$past(rx_odd_nibbles) && $past(rx_fcs_fail))
    else $error("crc count without crc error");
  chk_align_count: assert property (in_frame && len_ok && (align_err || code_err)
      |=> inc_q[RXS_CNT_ALIGN])
    else $error("align or code not counted");
  chk_short_not_counted: assert property (in_frame && rx_frame_length < RXS_MIN_FRAME_LEN
      |=> !inc_q[RXS_CNT_GOOD] && !inc_q[RXS_CNT_CRC] && !inc_q[RXS_CNT_ALIGN])
    else $error("short frame counted");
  chk_unmatched_ignored: assert property (rx_frame_done && !rx_addr_match |=> inc_q == '0)
    else $error("unmatched frame counted");
  chk_over_count: assert property (in_frame && len_over && !any_err
      |=> inc_q[RXS_CNT_OVER])
    else $error("oversize not counted");
  chk_over_not_good: assert property (inc_q[RXS_CNT_OVER] |-> !inc_q[RXS_CNT_GOOD])
    else $error("oversize counted good");
  chk_jabber_count: assert property (in_frame && len_over && any_err
      |=> inc_q[RXS_CNT_JABBER])
    else $error("jabber not counted");
  chk_code_latched: assert property (s_err_in_frame |=> code_seen)
    else $error("receive error not held");

  // interrupt, mask and bus paths
  chk_pend_follows_half: assert property (|half_bits |=> stats_irq_pending)
    else $error("pending missing");
  chk_mask_set_write: assert property (bus_wr_go && avs_address == RXS_OFS_MASK_SET
      && wdata_be[RXS_STATS_IRQ_PENDING_BIT] |=> stat_int_mask)
    else $error("mask set ignored");
  chk_mask_clr_write: assert property (bus_wr_go && avs_address == RXS_OFS_MASK_CLR
      && wdata_be[RXS_STATS_IRQ_PENDING_BIT] |=> !stat_int_mask)
    else $error("mask clear ignored");
  chk_masked_read_pend: assert property (avs_read && bus_state == RXS_BUS_IDLE
      && avs_address == RXS_OFS_MASKED
      |=> avs_readdata[RXS_STATS_IRQ_PENDING_BIT] == ($past(stats_irq_pending) && $past(stat_int_mask)))
    else $error("masked pending read wrong");
  chk_wrap_set_wins: assert property (|wrap_pulse
      |=> (wrap_status & $past(wrap_pulse)) == $past(wrap_pulse))
    else $error("wrap flag lost");
  chk_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
endmodule

// ==== rxs_mac_rx_model.sv ====
`timescale 1ns/1ps
module rxs_mac_rx_model
  import rxs_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // frame status towards the statistics block
  output logic             rx_frame_active,
  output logic             rx_error_input,
  output logic             rx_frame_done,
  output logic      [15:0] rx_frame_length,
  output logic      [47:0] rx_dest_addr,
  output logic             rx_addr_match,
  output logic             rx_is_data_or_ctrl,
  output logic      [15:0] rx_type_length,
  output logic      [15:0] rx_opcode,
  output logic             rx_odd_nibbles,
  output logic             rx_fcs_fail
);
  // no overrun indication is modelled, so overruns cannot reach any count
  initial begin
    {rx_frame_active, rx_error_input, rx_frame_done} = 3'h0;
    {rx_frame_length, rx_dest_addr, rx_type_length, rx_opcode} = '0;
    {rx_addr_match, rx_is_data_or_ctrl, rx_odd_nibbles, rx_fcs_fail} = 4'h0;
  end

  // fl = {match, data_or_ctrl, odd nibbles, fcs fail, receive error}
  task automatic send(input logic [15:0] len, input logic [47:0] da, input logic [4:0] fl,
                      input logic [15:0] tl, input logic [15:0] op);
    @(posedge clk_sys);
    rx_frame_active <= 1'b1;
    rx_error_input  <= fl[0]; // a whole cycle of receive error
    @(posedge clk_sys);
    rx_error_input  <= 1'b0;
    @(posedge clk_sys);
    rx_frame_active <= 1'b0;
    rx_frame_done   <= 1'b1;
    {rx_frame_length, rx_dest_addr, rx_type_length, rx_opcode} <= {len, da, tl, op};
    {rx_addr_match, rx_is_data_or_ctrl, rx_odd_nibbles, rx_fcs_fail} <= fl[4:1];
    @(posedge clk_sys);
    rx_frame_done <= 1'b0;
    // status only means something with done, so show a changed pattern afterwards
    {rx_frame_length, rx_dest_addr, rx_type_length, rx_opcode} <= ~{len, da, tl, op};
    {rx_addr_match, rx_is_data_or_ctrl, rx_odd_nibbles, rx_fcs_fail} <= ~fl[4:1];
  endtask
endmodule

// ==== rxs_rx_statistics_tb_top.sv ====
`timescale 1ns/1ps
module rxs_rx_statistics_tb_top
  import rxs_pkg::*;
  ;
  localparam logic [47:0] UC = 48'h0200_0000_0001;
  localparam logic [47:0] MC = 48'h0100_5E00_0001;
  localparam logic [4:0]  F_GOOD = 5'b11000, F_CRC = 5'b11010, F_ALN = 5'b11110;
  localparam logic [4:0]  F_ODD = 5'b11100, F_CODE = 5'b11001, F_CC = 5'b11011;
  localparam logic [4:0]  F_NOM = 5'b01000, F_NDC = 5'b10000;
  logic        clk_sys;
  logic        sys_rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_frame_active, rx_error_input, rx_frame_done, rx_addr_match;
  logic        rx_is_data_or_ctrl, rx_odd_nibbles, rx_fcs_fail, stats_irq;
  logic [15:0] rx_frame_length, rx_type_length, rx_opcode, max_len;
  logic [47:0] rx_dest_addr;
  logic [31:0] exp_cnt [8];
  logic [31:0] w;
  logic        pause_en;
  int          checked;
  int          miscompares;

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  rxs_rx_statistics DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_frame_active(rx_frame_active), .rx_error_input(rx_error_input),
    .rx_frame_done(rx_frame_done), .rx_frame_length(rx_frame_length),
    .rx_dest_addr(rx_dest_addr), .rx_addr_match(rx_addr_match),
    .rx_is_data_or_ctrl(rx_is_data_or_ctrl), .rx_type_length(rx_type_length),
    .rx_opcode(rx_opcode), .rx_odd_nibbles(rx_odd_nibbles), .rx_fcs_fail(rx_fcs_fail),
    .stats_irq(stats_irq));

  rxs_mac_rx_model u_mac (
    .clk_sys(clk_sys), .rx_frame_active(rx_frame_active), .rx_error_input(rx_error_input),
    .rx_frame_done(rx_frame_done), .rx_frame_length(rx_frame_length),
    .rx_dest_addr(rx_dest_addr), .rx_addr_match(rx_addr_match),
    .rx_is_data_or_ctrl(rx_is_data_or_ctrl), .rx_type_length(rx_type_length),
    .rx_opcode(rx_opcode), .rx_odd_nibbles(rx_odd_nibbles), .rx_fcs_fail(rx_fcs_fail));

  task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    cmp(nm, d, exp);
  endtask

  task automatic settle;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic chk_all;
    for (int i = 0; i < 8; i++) rd_cmp(8'(4 * i), exp_cnt[i], $sformatf("count %0d", i));
  endtask

  task automatic fr(input logic [15:0] len, input logic [47:0] da, input logic [4:0] fl,
                    input logic [15:0] tl = 16'h0800, input logic [15:0] op = 16'h0000);
    logic ok, ov, crc, al, ae, mt;
    ok  = len >= RXS_MIN_FRAME_LEN && len <= max_len;
    ov  = len > max_len;
    crc = !fl[2] && fl[1];
    al  = fl[2] && fl[1];
    ae  = crc || al || fl[0];
    mt  = fl[4] && fl[3];
    if (mt && ok && !ae) exp_cnt[0] += 32'h1;
    if (mt && ok && !ae && da == RXS_BCAST_ADDR) exp_cnt[1] += 32'h1;
    if (mt && ok && !ae && da[40] && da != RXS_BCAST_ADDR) exp_cnt[2] += 32'h1;
    if (mt && ok && !ae && pause_en && tl == 16'h8808 && op == 16'h0001) exp_cnt[3] += 32'h1;
    if (mt && ok && crc && !fl[0]) exp_cnt[4] += 32'h1;
    if (mt && ok && (al || fl[0])) exp_cnt[5] += 32'h1;
    if (mt && ov && !ae) exp_cnt[6] += 32'h1;
    if (mt && ov && ae) exp_cnt[7] += 32'h1;
    u_mac.send(len, da, fl, tl, op);
  endtask

  task automatic wrap_up;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    wrap_up();
  end

  initial begin
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 8'h00, 32'h0};
    avs_byteenable = 4'hF;
    {checked, miscompares, pause_en, max_len} = {32'd0, 32'd0, 1'b0, RXS_MAX_LEN_RESET};
    foreach (exp_cnt[i]) exp_cnt[i] = RXS_COUNT_RESET;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk_all();
    rd_cmp(RXS_OFS_MAX_LEN, 32'h0000_05EE, "max length");
    rd_cmp(RXS_OFS_MASK_SET, 32'h0, "mask");
    rd_cmp(RXS_OFS_PORT_CTRL, 32'h0, "port control");
    bus_wr(RXS_OFS_RAW_STAT, 32'hFFFF_FFFF);
    rd_cmp(RXS_OFS_RAW_STAT, 32'h0, "raw status");
    rd_cmp(8'h80, 32'h0, "unmapped");
    // boundaries, refusals and every error kind, back to back
    fr(16'd64, UC, F_GOOD);
    fr(16'd63, UC, F_GOOD);
    fr(16'd1518, RXS_BCAST_ADDR, F_GOOD);
    fr(16'd1519, UC, F_GOOD);
    fr(16'd100, MC, F_GOOD);
    fr(16'd64, UC, F_GOOD, RXS_PAUSE_TYPE, RXS_PAUSE_OPCODE);
    fr(16'd100, UC, F_NOM);
    fr(16'd100, UC, F_NDC);
    fr(16'd100, UC, F_CRC);
    fr(16'd100, UC, F_ALN);
    fr(16'd100, UC, F_ODD);
    fr(16'd100, UC, F_CODE);
    fr(16'd100, UC, F_CC);
    fr(16'd1519, UC, F_CRC);
    fr(16'd1519, MC, F_CODE);
    fr(16'd63, UC, F_CRC);
    settle();
    chk_all();
    bus_wr(RXS_OFS_PORT_CTRL, 32'h1);
    pause_en = 1'b1;
    fr(16'd64, UC, F_GOOD, RXS_PAUSE_TYPE, RXS_PAUSE_OPCODE);
    fr(16'd64, RXS_BCAST_ADDR, F_GOOD, RXS_PAUSE_TYPE, RXS_PAUSE_OPCODE);
    fr(16'd64, UC, F_CRC, RXS_PAUSE_TYPE, RXS_PAUSE_OPCODE);
    fr(16'd64, UC, F_GOOD, RXS_PAUSE_TYPE, 16'h0002);
    bus_wr(RXS_OFS_MAX_LEN, 32'h0000_0100);
    max_len = 16'h0100;
    rd_cmp(RXS_OFS_MAX_LEN, 32'h0000_0100, "max length");
    fr(16'd256, UC, F_GOOD);
    fr(16'd257, UC, F_GOOD);
    fr(16'd257, RXS_BCAST_ADDR, F_ALN);
    settle();
    chk_all();
    // sweep the decrement across the increment so one lands in the same cycle
    for (int k = 0; k < 6; k++) begin
      fork
        fr(16'd80, UC, F_GOOD);
        begin
          repeat (k) @(posedge clk_sys);
          bus_wr(RXS_OFS_CNT_BASE, 32'h1);
          exp_cnt[0] -= 32'h1;
        end
      join
    end
    settle();
    rd_cmp(RXS_OFS_CNT_BASE, exp_cnt[0], "good after collisions");
    w = exp_cnt[0] + 32'h1;
    bus_wr(RXS_OFS_CNT_BASE, w);
    settle();
    rd_cmp(RXS_OFS_CNT_BASE, 32'hFFFF_FFFF, "good after subtract");
    rd_cmp(RXS_OFS_RAW_STAT, 32'h1, "raw pending");
    rd_cmp(RXS_OFS_MASKED, 32'h0, "masked pending");
    cmp("irq masked off", {31'h0, stats_irq}, 32'h0);
    bus_wr(RXS_OFS_MASK_SET, 32'h1);
    settle();
    rd_cmp(RXS_OFS_MASKED, 32'h1, "masked pending");
    cmp("irq enabled", {31'h0, stats_irq}, 32'h1);
    bus_wr(RXS_OFS_MASK_CLR, 32'h1);
    settle();
    cmp("irq disabled", {31'h0, stats_irq}, 32'h0);
    bus_wr(RXS_OFS_MASK_SET, 32'h1);
    exp_cnt[0] = 32'hFFFF_FFFF;
    fr(16'd64, UC, F_GOOD);
    settle();
    rd_cmp(RXS_OFS_CNT_BASE, 32'h0, "good wrapped");
    rd_cmp(RXS_OFS_RAW_STAT, 32'h0, "raw after wrap");
    rd_cmp(RXS_OFS_WRAP_STAT, 32'h1, "wrap status");
    bus_wr(RXS_OFS_WRAP_EN, 32'h1);
    settle();
    cmp("irq on wrap", {31'h0, stats_irq}, 32'h1);
    bus_wr(RXS_OFS_WRAP_CLR, 32'h1);
    rd_cmp(RXS_OFS_WRAP_STAT, 32'h0, "wrap cleared");
    cmp("irq after wrap clear", {31'h0, stats_irq}, 32'h0);
    bus_wr(RXS_OFS_CNT_BASE, 32'h8000_0000);
    settle();
    cmp("irq at half scale", {31'h0, stats_irq}, 32'h1);
    bus_wr(RXS_OFS_CNT_BASE, 32'h1);
    settle();
    cmp("irq after decrement", {31'h0, stats_irq}, 32'h0);
    rd_cmp(RXS_OFS_CNT_BASE, 32'h7FFF_FFFF, "good below half");
    wrap_up();
  end
endmodule
